// [rtl/scrp_consts.svh]
// timing, step and field constants for the smart-card reset and power-down sequencer
`ifndef SCRP_CONSTS_SVH
`define SCRP_CONSTS_SVH
`define SCRP_ETU_NORM      9'h174
`define SCRP_ETU_FAST      9'h010
`define SCRP_RX_HIGH_CYC   16'h00C8
`define SCRP_ANS_MIN_CYC   16'h0190
`define SCRP_ANS_MAX_CYC   16'h9C40
`define SCRP_SYS_KHZ       50000
`define SCRP_CARD_MAX_KHZ  5000
`define SCRP_CARD_HALF     ((`SCRP_SYS_KHZ + 2 * `SCRP_CARD_MAX_KHZ - 1) / (2 * `SCRP_CARD_MAX_KHZ))
`define SCRP_PWR_SETTLE    16'h0064
`define SCRP_PD_STEPS      4
`define SCRP_STG_RST       0
`define SCRP_STG_CLK       1
`define SCRP_STG_TX        2
`define SCRP_STG_VEN       3
`endif

// [rtl/scrp_pkg.sv]
// types for the smart-card reset and power-down sequencer
`include "scrp_consts.svh"
package scrp_pkg;
    typedef enum logic [4:0] {
        SCRP_OFF    = 5'h01,
        SCRP_POWER  = 5'h02,
        SCRP_ANSWER = 5'h04,
        SCRP_ACTIVE = 5'h08,
        SCRP_DOWN   = 5'h10
    } scrp_state_t;

    typedef struct packed {
        logic rst_n;
        logic clk;
        logic tx;
        logic ven;
        logic io_o;
        logic io_oe;
    } scrp_pins_t;

    typedef struct packed {
        scrp_state_t                   st;
        scrp_pins_t                    pins;
        logic                          clk_run;
        logic [7:0]                    div;
        logic [15:0]                   cnt;
        logic [8:0]                    etu;
        logic                          pres_m;
        logic                          pres_s;
        logic                          rx_m;
        logic                          rx_s;
        logic                          rx_q;
        logic [`SCRP_PD_STEPS-1:0]     stg_m;
        logic [`SCRP_PD_STEPS-1:0]     stg_s;
        logic                          etu_tick;
        logic                          ev_ans;
        logic                          ev_early;
        logic                          ev_tmo;
        logic                          ev_rem;
    } scrp_sys_t;

    typedef struct packed {
        logic                          nrst_m;
        logic                          nrst_s;
        logic                          go_m;
        logic                          go_s;
        logic [`SCRP_PD_STEPS-1:0]     stage;
    } scrp_slow_t;
endpackage : scrp_pkg

// [rtl/scrp_seq.sv]
// smart-card clock, answer-window and ordered power-down sequencer
`include "scrp_consts.svh"
module scrp_seq
    import scrp_pkg::*;
#(
    parameter int          CARD_HALF  = `SCRP_CARD_HALF,
    parameter logic [15:0] PWR_SETTLE = `SCRP_PWR_SETTLE
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic slow_reference_clock,
    input  wire logic start_req,
    input  wire logic stop_req,
    input  wire logic rate_fast,
    input  wire logic bidir_sel,
    input  wire logic tx_bit,
    input  wire logic card_presence_detect,
    input  wire logic card_rx,
    input  wire logic card_bidir_data_i,
    output logic      card_bidir_data_o,
    output logic      card_bidir_data_oe,
    output logic      card_clock_out,
    output logic      card_rst_n,
    output logic      card_tx,
    output logic      card_ven,
    output logic      rx_bit,
    output logic      etu_tick,
    output logic      answer_start,
    output logic      answer_early,
    output logic      answer_timeout,
    output logic      card_removed,
    output logic      card_active,
    output logic      seq_busy
);
    localparam scrp_sys_t SYS_RST = '{st: SCRP_OFF, default: '0};

    scrp_sys_t  r;
    scrp_sys_t  next_r;
    scrp_slow_t sr;
    scrp_slow_t next_sr;

    always_comb begin
        logic ck_rise;
        logic rx_fall;
        logic live;
        logic down;
        logic txv;
        logic tx_lvl;
        ck_rise = 1'b0;
        rx_fall = 1'b0;
        live    = 1'b0;
        down    = 1'b0;
        txv     = 1'b0;
        tx_lvl  = 1'b0;
        next_r  = r;
        // the presence and receive pins are asynchronous to clk_sys
        next_r.pres_m = card_presence_detect;
        next_r.pres_s = r.pres_m;
        next_r.rx_m   = bidir_sel ? card_bidir_data_i : card_rx;
        next_r.rx_s   = r.rx_m;
        next_r.rx_q   = r.rx_s;
        next_r.stg_m  = sr.stage;
        next_r.stg_s  = r.stg_m;
        next_r.etu_tick = 1'b0;
        next_r.ev_ans   = 1'b0;
        next_r.ev_early = 1'b0;
        next_r.ev_tmo   = 1'b0;
        next_r.ev_rem   = 1'b0;
        rx_fall = r.rx_q && !r.rx_s;

        if (r.clk_run) begin
            if (r.div == 8'(CARD_HALF - 1)) begin
                next_r.div      = 8'h00;
                next_r.pins.clk = !r.pins.clk;
                ck_rise         = !r.pins.clk;
            end else begin
                next_r.div = r.div + 8'h01;
            end
        end else begin
            next_r.div      = 8'h00;
            next_r.pins.clk = 1'b0;
        end

        if (ck_rise) begin
            if (r.cnt != 16'hFFFF) begin
                next_r.cnt = r.cnt + 16'h0001;
            end
            // bit period in card clocks for the framing logic
            if (r.etu == (rate_fast ? `SCRP_ETU_FAST : `SCRP_ETU_NORM) - 9'h001) begin
                next_r.etu      = 9'h000;
                next_r.etu_tick = 1'b1;
            end else begin
                next_r.etu = r.etu + 9'h001;
            end
        end

        unique case (r.st)
            SCRP_OFF: begin
                // a fresh power-up waits until the slow side has cleared its steps
                if (start_req && r.pres_s && r.stg_s == '0) begin
                    next_r.st  = SCRP_POWER;
                    next_r.cnt = 16'h0000;
                end
            end
            SCRP_POWER: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == PWR_SETTLE - 16'h0001) begin
                    next_r.st  = SCRP_ANSWER;
                    next_r.cnt = 16'h0000;
                    next_r.etu = 9'h000;
                end
            end
            SCRP_ANSWER: begin
                // falls before the line is due high are the card settling, not an answer
                if (rx_fall && r.cnt >= `SCRP_RX_HIGH_CYC) begin
                    next_r.st       = SCRP_ACTIVE;
                    next_r.ev_ans   = 1'b1;
                    next_r.ev_early = r.cnt < `SCRP_ANS_MIN_CYC;
                end else if (r.cnt == `SCRP_ANS_MAX_CYC) begin
                    next_r.st     = SCRP_DOWN;
                    next_r.ev_tmo = 1'b1;
                end
            end
            SCRP_ACTIVE: begin
            end
            SCRP_DOWN: begin
                if (r.stg_s == '1 && !r.pins.ven) begin
                    next_r.st = SCRP_OFF;
                end
            end
        endcase

        live = r.st == SCRP_POWER || r.st == SCRP_ANSWER || r.st == SCRP_ACTIVE;
        if (live && (!r.pres_s || stop_req)) begin
            next_r.st     = SCRP_DOWN;
            next_r.ev_rem = !r.pres_s;
        end

        // a pin falls once its slow step has crossed and the pin before it is low, so the
        // order holds even when several steps arrive in one system clock; reset, clk_run, tx and
        // power never rise in power-down, so an abort during the settle wait keeps reset and clock low
        down   = next_r.st == SCRP_DOWN;
        tx_lvl = bidir_sel ? !r.pins.io_oe : r.pins.tx;
        if (down) begin
            next_r.pins.rst_n = r.pins.rst_n && !r.stg_s[`SCRP_STG_RST];
            next_r.clk_run    = r.clk_run && !(r.stg_s[`SCRP_STG_CLK] && !r.pins.rst_n);
            txv = tx_lvl && !(r.stg_s[`SCRP_STG_TX] && !r.clk_run && !r.pins.clk);
            next_r.pins.ven   = r.pins.ven && !(r.stg_s[`SCRP_STG_VEN] && !tx_lvl);
        end else begin
            next_r.pins.rst_n = next_r.st == SCRP_ANSWER || next_r.st == SCRP_ACTIVE;
            next_r.clk_run    = next_r.pins.rst_n;
            txv = (next_r.st == SCRP_ACTIVE) ? tx_bit : next_r.st == SCRP_ANSWER;
            next_r.pins.ven   = next_r.st != SCRP_OFF;
        end
        // shared line is open drain: only a low is driven
        next_r.pins.tx    = bidir_sel ? 1'b0 : txv;
        next_r.pins.io_o  = 1'b0;
        next_r.pins.io_oe = bidir_sel && !txv;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            r <= SYS_RST;
        end else begin
            r <= next_r;
        end
    end

    // slow side: reset and start level both cross in through two flops
    always_comb begin
        next_sr        = sr;
        next_sr.nrst_m = nrst;
        next_sr.nrst_s = sr.nrst_m;
        // only the one-hot flop of the down state crosses, never a decode of several
        next_sr.go_m   = (r.st & SCRP_DOWN) != '0;
        next_sr.go_s   = sr.go_m;
        if (!sr.nrst_s || !sr.go_s) begin
            next_sr.stage = '0;
        end else begin
            // thermometer code, so each bit crosses back safely on its own
            next_sr.stage = {sr.stage[`SCRP_PD_STEPS-2:0], 1'b1};
        end
    end

    always_ff @(posedge slow_reference_clock) begin
        sr <= next_sr;
    end

    assign card_clock_out     = r.pins.clk;
    assign card_rst_n         = r.pins.rst_n;
    assign card_tx            = r.pins.tx;
    assign card_ven           = r.pins.ven;
    assign card_bidir_data_o  = r.pins.io_o;
    assign card_bidir_data_oe = r.pins.io_oe;
    assign rx_bit             = r.rx_s;
    assign etu_tick           = r.etu_tick;
    assign answer_start       = r.ev_ans;
    assign answer_early       = r.ev_early;
    assign answer_timeout     = r.ev_tmo;
    assign card_removed       = r.ev_rem;
    assign card_active        = r.st == SCRP_ACTIVE;
    assign seq_busy           = r.st == SCRP_DOWN;

    // two clock domains here, so every property names its own clock and reset
    off_pins_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (r.st == SCRP_OFF && $past(r.st) == SCRP_OFF)
        |-> !card_ven && !card_clock_out && !card_rst_n)
        else $error("pins not low while off");
    rst_before_clk_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (r.st == SCRP_DOWN && !r.clk_run) |-> !card_rst_n)
        else $error("clock stopped before reset fell");
    ven_last_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (r.st == SCRP_DOWN && !card_ven) |-> !card_clock_out && !card_rst_n && !card_tx
        && (card_bidir_data_oe || !bidir_sel))
        else $error("power dropped before other pins");
    removal_down_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((r.st == SCRP_ANSWER || r.st == SCRP_ACTIVE) && !r.pres_s)
        |=> r.st == SCRP_DOWN && card_removed)
        else $error("removal did not start power-down");
    stop_down_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (r.st == SCRP_ACTIVE && stop_req) |=> r.st == SCRP_DOWN)
        else $error("stop request ignored");
    timeout_at_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        answer_timeout |-> $past(r.cnt) == `SCRP_ANS_MAX_CYC && $past(r.st) == SCRP_ANSWER)
        else $error("timeout not at window end");
    answer_window_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        answer_start |-> $past(r.cnt) >= `SCRP_RX_HIGH_CYC && $past(r.cnt) <= `SCRP_ANS_MAX_CYC)
        else $error("answer taken outside window");
    clk_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(r.st == SCRP_ANSWER) |-> r.cnt == 16'h0000 && card_ven ##1 r.clk_run)
        else $error("answer count not started with clock");
    etu_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        etu_tick |=> !etu_tick [*8])
        else $error("bit ticks too close");
    shared_line_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(bidir_sel) |-> !card_tx && !(card_bidir_data_oe && card_bidir_data_o))
        else $error("shared mode drives tx or a high");
    slow_step_a: assert property (
        @(posedge slow_reference_clock) disable iff (!sr.nrst_s)
        sr.go_s |=> sr.stage == {$past(sr.stage[`SCRP_PD_STEPS-2:0]), 1'b1})
        else $error("power-down step not one per slow period");

    answer_ok_c:   cover property (@(posedge clk_sys) disable iff (!nrst)
        answer_start && !answer_early);
    timeout_c:     cover property (@(posedge clk_sys) disable iff (!nrst) answer_timeout);
    full_down_c:   cover property (@(posedge clk_sys) disable iff (!nrst)
        r.st == SCRP_DOWN ##1 r.st == SCRP_OFF);
    fast_rate_c:   cover property (@(posedge clk_sys) disable iff (!nrst) rate_fast && etu_tick);
    removal_c:     cover property (@(posedge clk_sys) disable iff (!nrst) card_removed);
endmodule : scrp_seq

// [test/scrp_card_model.sv]
// behavioural smart card: answers on its receive line at a chosen card clock count
module scrp_card_model (
    input  wire logic card_clock_out,
    input  wire logic card_ven,
    input  wire logic [31:0] answer_at,
    output logic      card_rx
);
    timeunit 1ns;
    timeprecision 100ps;
    int n;
    // count card clocks from clock start; an unpowered card leaves the line low
    always @(posedge card_clock_out or negedge card_ven) begin
        if (!card_ven) begin
            n <= 0;
        end else begin
            n <= n + 1;
        end
    end
    // line high by count 100, answer start bit lasts 10 card clocks; 0 means mute card
    assign card_rx = card_ven && (n >= 100) &&
        !(answer_at != 0 && n >= answer_at && n < answer_at + 10);
endmodule : scrp_card_model

// [test/test_scrp_seq.sv]
// self-checking bench for the card reset and power-down sequencer
module test_scrp_seq;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 0, slow = 0, nrst = 0, start_req = 0, stop_req = 0;
    logic rate_fast = 0, bidir_sel = 0, tx_bit = 1, pres = 1;
    logic io_o, io_oe, cclk, rst_n, ctx, ven, rx_bit, etu, ans, early, tmo, rem, act, busy;
    logic card_rx, line;
    int   answer_at = 0;
    int   err_total = 0;
    int   num_checks = 0;
    always #10 clk_sys = ~clk_sys;
    initial #1.7 forever #3 slow = ~slow;
    // open drain shared line with pull-up: low if either party pulls it
    assign line = card_rx & !io_oe;
    scrp_seq #(.CARD_HALF(1), .PWR_SETTLE(16'h0004)) scrp_seq_inst (
        .clk_sys(clk_sys), .nrst(nrst), .slow_reference_clock(slow),
        .start_req(start_req), .stop_req(stop_req), .rate_fast(rate_fast),
        .bidir_sel(bidir_sel), .tx_bit(tx_bit), .card_presence_detect(pres),
        .card_rx(line), .card_bidir_data_i(line), .card_bidir_data_o(io_o),
        .card_bidir_data_oe(io_oe), .card_clock_out(cclk), .card_rst_n(rst_n),
        .card_tx(ctx), .card_ven(ven), .rx_bit(rx_bit), .etu_tick(etu),
        .answer_start(ans), .answer_early(early), .answer_timeout(tmo),
        .card_removed(rem), .card_active(act), .seq_busy(busy));
    scrp_card_model scrp_card_model_inst (
        .card_clock_out(cclk), .card_ven(ven), .answer_at(answer_at), .card_rx(card_rx));

    task automatic check(input string name, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // power the card, wait for its answer, then time two bit ticks
    task automatic power_up(input logic fast, input logic bidir, input int at);
        int  t0;
        logic seen_ans = 0, seen_early = 0, toggled = 0;
        @(negedge clk_sys);
        answer_at = at;
        rate_fast = fast;
        bidir_sel = bidir;
        start_req = 1;
        for (int i = 0; i < 3000 && !seen_ans; i++) begin
            @(posedge clk_sys);
            #1;
            toggled |= cclk;
            seen_ans |= ans;
            seen_early |= early;
        end
        @(negedge clk_sys);
        start_req = 0;
        check("answer_start", seen_ans, 1'b1);
        check("answer_early", seen_early, at < 400);
        check("card_clock_out", toggled, 1'b1);
        check("answer_timeout", tmo, 1'b0);
        @(negedge clk_sys);
        check("card_active", act, 1'b1);
        check("card_rst_n", rst_n, 1'b1);
        check("card_tx", ctx, !bidir);
        check("card_bidir_data_o", io_o, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 2000 && !etu; i++) @(negedge clk_sys);
            if (k == 0) t0 = $time;
            @(negedge clk_sys);
        end
        // card clock period is 2 system clocks with CARD_HALF 1
        check("etu_spacing", ($time - 20 - t0) == (fast ? 32 : 744) * 20, 1'b1);
    endtask : power_up

    // stop by request or by removal and watch the order in which pins fall
    task automatic power_down(input logic removal);
        int  t_rst = -1, t_tx = -1, t_ven = -1;
        logic seen_rem = 0;
        @(negedge clk_sys);
        if (removal) pres = 0;
        else stop_req = 1;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_sys);
            seen_rem |= rem;
            if (!rst_n && t_rst < 0) t_rst = i;
            if (!ctx && !io_oe && t_tx < 0 && !bidir_sel) t_tx = i;
            if (io_oe && t_tx < 0) t_tx = i;
            if (!ven && t_ven < 0) t_ven = i;
        end
        check("card_removed", seen_rem, removal);
        check("step_order", t_rst >= 0 && t_rst < t_tx && t_tx < t_ven, 1'b1);
        check("card_clock_out", cclk, 1'b0);
        check("card_ven", ven, 1'b0);
        check("seq_busy", busy, 1'b0);
        stop_req = 0;
        pres = 1;
        repeat (20) @(negedge clk_sys);
    endtask : power_down

    // mute card: the window closes after 40000 card clocks and the card is powered down
    task automatic answer_missing();
        int   i_tmo = -1;
        logic seen_ans = 0, seen_rem = 0;
        @(negedge clk_sys);
        answer_at = 0;
        rate_fast = 0;
        bidir_sel = 0;
        start_req = 1;
        for (int i = 0; i < 82000 && i_tmo < 0; i++) begin
            @(posedge clk_sys);
            #1;
            seen_ans |= ans;
            if (tmo) i_tmo = i;
        end
        @(negedge clk_sys);
        start_req = 0;
        // 4 settle cycles, then 2 system clocks per card clock
        check("timeout_cycle", i_tmo >= 80000 && i_tmo <= 80010, 1'b1);
        check("answer_start", seen_ans, 1'b0);
        repeat (300) begin
            @(negedge clk_sys);
            seen_rem |= rem;
        end
        check("card_removed", seen_rem, 1'b0);
        check("card_ven", ven, 1'b0);
        check("seq_busy", busy, 1'b0);
    endtask : answer_missing

    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1;
        repeat (4) @(negedge clk_sys);
        power_up(1'b0, 1'b0, 500);
        power_down(1'b0);
        power_up(1'b1, 1'b1, 300);
        power_down(1'b1);
        answer_missing();
        summarize();
    end

    // the scenarios need about 84000 system clocks, most of it the mute-card window
    initial begin
        #(20 * 95000);
        err_total++;
        summarize();
    end
endmodule : test_scrp_seq
